// ==== design/ormp_defines.svh ====
// Constants of the OR, copy and pointer-load execute block
`ifndef ORMP_DEFINES_SVH
`define ORMP_DEFINES_SVH

`define ORMP_INSTR_W      16
`define ORMP_DATA_W       8
`define ORMP_ADDR_W       12
`define ORMP_BANK_W       4
`define ORMP_NUM_PTR      3

// Opcode fields and their match values
`define ORMP_OP8_HI       15
`define ORMP_OP8_LO       8
`define ORMP_OP6_LO       10
`define ORMP_OP10_LO      6
`define ORMP_OPC_IOR_LIT  8'h09
`define ORMP_OPC_IOR_FILE 6'h04
`define ORMP_OPC_COPY     6'h14
`define ORMP_OPC_PTR_HI   10'h3b8
`define ORMP_OPC_PTR_LO   8'hf0

// Operand fields
`define ORMP_DEST_BIT     9
`define ORMP_ACC_BIT      8
`define ORMP_LIT_HI       7
`define ORMP_LIT_LO       0
`define ORMP_PSEL_HI      5
`define ORMP_PSEL_LO      4
`define ORMP_KHI_HI       3
`define ORMP_KHI_LO       0
`define ORMP_PTR_HB_HI    11
`define ORMP_PTR_HB_LO    8
`define ORMP_PTR_LB_HI    7
`define ORMP_PTR_LB_LO    0
`define ORMP_SIGN_BIT     7

// Operand addressing
`define ORMP_IDX_LIMIT    8'h5f
`define ORMP_ACC_SPLIT    8'h60
`define ORMP_ACC_LOW_BANK 4'h0
`define ORMP_ACC_SFR_BANK 4'hf
`define ORMP_IDX_PTR      2
`define ORMP_PSEL_MAX     2'h2

// Reset values
`define ORMP_W_RST        8'h00
`define ORMP_PTR_RST      12'h000

`endif

// ==== design/ormp_pkg.sv ====
// Types of the OR, copy and pointer-load execute block
`include "ormp_defines.svh"

package ormp_pkg;

  typedef enum logic [3:0] {
    PH_Q1 = 4'h1,
    PH_Q2 = 4'h2,
    PH_Q3 = 4'h4,
    PH_Q4 = 4'h8
  } ormp_phase_e;

  typedef enum logic [1:0] {
    SEQ_RUN = 2'h1,
    SEQ_LOW = 2'h2
  } ormp_seq_e;

  typedef enum logic [5:0] {
    OP_NONE     = 6'h01,
    OP_IOR_LIT  = 6'h02,
    OP_IOR_FILE = 6'h04,
    OP_COPY     = 6'h08,
    OP_PTR_HI   = 6'h10,
    OP_PTR_LO   = 6'h20
  } ormp_op_e;

  typedef logic [`ORMP_ADDR_W-1:0] ormp_ptr_t;

  typedef struct packed {
    logic                    rd_en;
    logic                    wr_en;
    logic [`ORMP_ADDR_W-1:0] addr;
    logic [`ORMP_DATA_W-1:0] wdata;
  } ormp_mem_s;

  typedef struct packed {
    ormp_phase_e                     phase;
    ormp_seq_e                       seq;
    ormp_op_e                        op;
    logic                            dest_file;
    logic [1:0]                      psel;
    logic [`ORMP_DATA_W-1:0]         opnd;
    logic [`ORMP_DATA_W-1:0]         w;
    logic                            neg;
    logic                            zero;
    ormp_ptr_t [`ORMP_NUM_PTR-1:0]   ptr;
    ormp_mem_s                       mem;
  } ormp_state_s;

endpackage

// ==== design/ormp_core.sv ====
// Decode and execute of OR, copy-file and pointer-load instructions
`timescale 1ns/100ps
`default_nettype none
`include "ormp_defines.svh"

module ormp_core
  import ormp_pkg::*;
(
  input  wire logic                          mclk_i,        // Core clock, 4 per instr cycle
  input  wire logic                          rst_b_i,       // Async reset, active low
  input  wire logic [`ORMP_INSTR_W-1:0]      instr_i,       // Instruction word
  input  wire logic                          instr_vld_i,   // Word valid, taken in Q1
  input  wire logic                          ext_set_en_i,  // Extended instruction set on
  input  wire logic [`ORMP_BANK_W-1:0]       bank_select_register_i, // Bank select
  input  wire logic [`ORMP_DATA_W-1:0]       rdata_i,       // File read data during Q2
  output var  ormp_mem_s                     mem_o,         // File register access
  output logic [`ORMP_DATA_W-1:0]            w_o,           // Working register
  output logic                               neg_o,         // Sign flag
  output logic                               zero_o,        // Zero flag
  output ormp_ptr_t [`ORMP_NUM_PTR-1:0]      ptr_o,         // File pointer registers
  output logic [3:0]                         phase_o,       // One-hot quarter phase
  output logic                               second_word_o  // Awaiting pointer low word
);

  ormp_state_s q;
  ormp_state_s d;

  // Operand address resolution for byte-oriented file instructions
  function automatic logic [`ORMP_ADDR_W-1:0] resolve_addr(
    input logic                          acc_bank,
    input logic [`ORMP_DATA_W-1:0]       f,
    input logic                          ext_en,
    input logic [`ORMP_BANK_W-1:0]       bank,
    input ormp_ptr_t                     base
  );
    logic [`ORMP_ADDR_W-1:0] a;
    a = {bank, f};
    if (!acc_bank) begin
      if (ext_en && (f <= `ORMP_IDX_LIMIT)) begin
        // Offset wraps in the 4 KB space, as the pointer itself does
        a = base + {{(`ORMP_ADDR_W-`ORMP_DATA_W){1'b0}}, f};
      end else if (f < `ORMP_ACC_SPLIT) begin
        a = {`ORMP_ACC_LOW_BANK, f};
      end else begin
        a = {`ORMP_ACC_SFR_BANK, f};
      end
    end
    return a;
  endfunction

  function automatic logic sign_of(input logic [`ORMP_DATA_W-1:0] r);
    return r[`ORMP_SIGN_BIT];
  endfunction

  function automatic logic zero_of(input logic [`ORMP_DATA_W-1:0] r);
    return (r == '0);
  endfunction

  logic [`ORMP_DATA_W-1:0] result;

  always_comb begin
    d = q;
    result = '0;
    d.mem.rd_en = 1'b0;
    d.mem.wr_en = 1'b0;
    case (q.phase)
      PH_Q1: begin
        d.phase = PH_Q2;
        d.op = OP_NONE;
        if (instr_vld_i) begin
          if (q.seq == SEQ_LOW) begin
            // Second word carries the low byte; its opcode bits are not checked
            d.op = OP_PTR_LO;
            d.opnd = instr_i[`ORMP_LIT_HI:`ORMP_LIT_LO];
          end else if (instr_i[`ORMP_OP8_HI:`ORMP_OP8_LO] == `ORMP_OPC_IOR_LIT) begin
            d.op = OP_IOR_LIT;
            d.opnd = instr_i[`ORMP_LIT_HI:`ORMP_LIT_LO];
          end else if ((instr_i[`ORMP_OP8_HI:`ORMP_OP6_LO] == `ORMP_OPC_IOR_FILE) ||
                       (instr_i[`ORMP_OP8_HI:`ORMP_OP6_LO] == `ORMP_OPC_COPY)) begin
            d.op = (instr_i[`ORMP_OP8_HI:`ORMP_OP6_LO] == `ORMP_OPC_COPY) ?
                   OP_COPY : OP_IOR_FILE;
            d.dest_file = instr_i[`ORMP_DEST_BIT];
            d.mem.rd_en = 1'b1;
            d.mem.addr = resolve_addr(instr_i[`ORMP_ACC_BIT],
                                      instr_i[`ORMP_LIT_HI:`ORMP_LIT_LO],
                                      ext_set_en_i,
                                      bank_select_register_i,
                                      q.ptr[`ORMP_IDX_PTR]);
          end else if (instr_i[`ORMP_OP8_HI:`ORMP_OP10_LO] == `ORMP_OPC_PTR_HI) begin
            d.op = OP_PTR_HI;
            d.psel = instr_i[`ORMP_PSEL_HI:`ORMP_PSEL_LO];
            d.opnd = {{(`ORMP_DATA_W-4){1'b0}}, instr_i[`ORMP_KHI_HI:`ORMP_KHI_LO]};
          end
        end
      end
      PH_Q2: begin
        d.phase = PH_Q3;
        if (q.mem.rd_en) begin
          d.opnd = rdata_i;
        end
      end
      PH_Q3: begin
        d.phase = PH_Q4;
        case (q.op)
          OP_IOR_LIT: begin
            result = q.w | q.opnd;
            d.w = result;
            d.neg = sign_of(result);
            d.zero = zero_of(result);
          end
          OP_IOR_FILE, OP_COPY: begin
            result = (q.op == OP_COPY) ? q.opnd : (q.w | q.opnd);
            d.neg = sign_of(result);
            d.zero = zero_of(result);
            if (q.dest_file) begin
              d.mem.wr_en = 1'b1;
              d.mem.wdata = result;
            end else begin
              d.w = result;
            end
          end
          OP_PTR_HI: begin
            // A selector of 3 names no pointer; the load still takes a second word
            if (q.psel <= `ORMP_PSEL_MAX) begin
              d.ptr[q.psel][`ORMP_PTR_HB_HI:`ORMP_PTR_HB_LO] =
                q.opnd[`ORMP_KHI_HI:`ORMP_KHI_LO];
            end
            d.seq = SEQ_LOW;
          end
          OP_PTR_LO: begin
            if (q.psel <= `ORMP_PSEL_MAX) begin
              d.ptr[q.psel][`ORMP_PTR_LB_HI:`ORMP_PTR_LB_LO] = q.opnd;
            end
            d.seq = SEQ_RUN;
          end
          default: begin
          end
        endcase
      end
      PH_Q4: begin
        d.phase = PH_Q1;
      end
      default: begin
        d.phase = PH_Q1;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '{phase: PH_Q1, seq: SEQ_RUN, op: OP_NONE, w: `ORMP_W_RST,
             ptr: {`ORMP_NUM_PTR{`ORMP_PTR_RST}}, default: '0};
    end else begin
      q <= d;
    end
  end

  assign mem_o         = q.mem;
  assign w_o           = q.w;
  assign neg_o         = q.neg;
  assign zero_o        = q.zero;
  assign ptr_o         = q.ptr;
  assign phase_o       = q.phase;
  assign second_word_o = (q.seq == SEQ_LOW);

endmodule
`default_nettype wire

// ==== verif/ormp_chk.sv ====
// Port checker of the OR, copy and pointer-load block
`timescale 1ns/100ps
`default_nettype none
`include "ormp_defines.svh"
module ormp_chk
  import ormp_pkg::*;
(
  input wire logic            mclk_i,        // Clock
  input wire logic            rst_b_i,       // Reset
  input wire logic [15:0]     instr_i,       // Word
  input wire logic            instr_vld_i,   // Valid
  input wire logic            ext_set_en_i,  // Ext set
  input wire logic [3:0]      bank_select_register_i, // Bank
  input wire logic [7:0]      rdata_i,       // Read data
  input wire ormp_mem_s       mem_o,         // Access
  input wire logic [7:0]      w_o,           // W
  input wire logic            neg_o,         // Sign
  input wire logic            zero_o,        // Zero
  input wire ormp_ptr_t [2:0] ptr_o,         // Pointers
  input wire logic [3:0]      phase_o,       // Phase
  input wire logic            second_word_o  // Low pending
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // A low word is never decoded, so the opcode match must skip it
  wire logic        tk  = phase_o == 4'h1 && instr_vld_i && !second_word_o;
  wire logic [7:0]  f   = instr_i[7:0];
  wire logic [11:0] p2  = ptr_o[2];
  wire logic [1:0]  ps  = instr_i[5:4];
  wire logic [3:0]  kh  = instr_i[3:0];
  wire logic        fop = tk && (instr_i[15:10] == 6'h04 || instr_i[15:10] == 6'h14);
  lit_or_a: assert property (
    tk && instr_i[15:8] == 8'h09 |-> ##3 w_o == ($past(w_o, 3) | $past(f, 3))
    && neg_o == w_o[7] && zero_o == (w_o == 8'h00)) else $error("literal OR wrong");
  file_or_w_a: assert property (
    tk && instr_i[15:10] == 6'h04 && !instr_i[9] |-> ##3
    w_o == ($past(w_o, 3) | $past(rdata_i, 2)) && !mem_o.wr_en) else $error("file OR wrong");
  copy_back_a: assert property (
    tk && instr_i[15:10] == 6'h14 && instr_i[9] |-> ##3 mem_o.wr_en
    && mem_o.wdata == $past(rdata_i, 2) && w_o == $past(w_o, 3)) else $error("copy wrong");
  bank_addr_a: assert property (
    fop && instr_i[8] |=> mem_o.rd_en && mem_o.addr == {$past(bank_select_register_i),
    $past(f)} ##1 !mem_o.rd_en) else $error("banked address wrong");
  acc_addr_a: assert property (
    fop && !instr_i[8] && !ext_set_en_i |=> mem_o.addr == ($past(f) < 8'h60 ?
    {4'h0, $past(f)} : {4'hf, $past(f)})) else $error("access address wrong");
  idx_addr_a: assert property (
    fop && !instr_i[8] && ext_set_en_i && f <= 8'h5f |=>
    mem_o.addr == $past(p2) + $past(f)) else $error("indexed address wrong");
  ptr_high_a: assert property (
    tk && instr_i[15:6] == 10'h3b8 && ps != 2'h3 |-> ##3 second_word_o
    && ptr_o[$past(ps, 3)][11:8] == $past(kh, 3) && neg_o == $past(neg_o, 3))
    else $error("pointer high wrong");
  ptr_low_a: assert property (
    phase_o == 4'h1 && instr_vld_i && second_word_o |-> ##3 !second_word_o
    && zero_o == $past(zero_o, 3)) else $error("pointer low wrong");
  phase_ring_a: assert property (
    1'b1 |=> phase_o == {$past(phase_o[2:0]), $past(phase_o[3])})
    else $error("phase ring broken");
  cover property (fop && ext_set_en_i && !instr_i[8] && f <= 8'h5f);
  cover property (tk && instr_i[15:8] == 8'h09);
  cover property (phase_o == 4'h1 && instr_vld_i && second_word_o);
endmodule
bind ormp_core ormp_chk u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .instr_i(instr_i),
  .instr_vld_i(instr_vld_i), .ext_set_en_i(ext_set_en_i), .rdata_i(rdata_i),
  .bank_select_register_i(bank_select_register_i), .mem_o(mem_o), .w_o(w_o),
  .neg_o(neg_o), .zero_o(zero_o), .ptr_o(ptr_o), .phase_o(phase_o),
  .second_word_o(second_word_o));
`default_nettype wire

// ==== verif/tb_or_move_pointer_load_execute.sv ====
// Self-checking bench of the OR, copy and pointer-load block
`timescale 1ns/100ps
`default_nettype none
`include "ormp_defines.svh"
module tb_or_move_pointer_load_execute
  import ormp_pkg::*;
;
  logic            mclk = 1'b0, rst_b = 1'b0, vld = 1'b0, ext = 1'b0;
  logic [15:0]     ins = 16'h0000;
  logic [3:0]      bank = 4'h0, kh;
  logic [7:0]      rd = 8'h00, w_o, wd, k, r, fa, res;
  ormp_mem_s       mem;
  logic            neg, zer, sw, wr, d, a;
  logic [3:0]      ph;
  ormp_ptr_t [2:0] ptr;
  logic [1:0]      kd, s;
  logic [9:0]      e = 10'h000;
  logic [11:0]     pm [3] = '{default: 12'h000};
  int              fails = 0, comparisons = 0, cyc = 0;
  ormp_core u_ormp_core (.mclk_i(mclk), .rst_b_i(rst_b), .instr_i(ins), .instr_vld_i(vld),
    .ext_set_en_i(ext), .bank_select_register_i(bank), .rdata_i(rd), .mem_o(mem),
    .w_o(w_o), .neg_o(neg), .zero_o(zer), .ptr_o(ptr), .phase_o(ph), .second_word_o(sw));
  function automatic logic [9:0] flg(input logic [7:0] wn, input logic [7:0] v);
    return {wn, v[7], v == 8'h00};
  endfunction
  task automatic report(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One compare per kind of result: W with flags, file write, pointers, word sequence
  task automatic cmp_reg(input logic [9:0] got, input logic [9:0] exp);
    report({26'h0, got}, {26'h0, exp});
  endtask
  task automatic cmp_mem(input logic [8:0] got, input logic [8:0] exp);
    report({27'h0, got}, {27'h0, exp});
  endtask
  task automatic cmp_ptr(input logic [35:0] got, input logic [35:0] exp);
    report(got, exp);
  endtask
  task automatic cmp_seq(input logic got, input logic exp);
    report({35'h0, got}, {35'h0, exp});
  endtask
  task automatic wrap_up();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Entered at a falling edge in Q1; read data is r during Q2 and inverted from Q3 on
  task automatic word(input logic [15:0] i, input logic v);
    ins = i;
    vld = v;
    @(negedge mclk);
    vld = 1'b0;
    ins = ~i;
    rd = r;
    @(negedge mclk);
    rd = ~r;
    @(negedge mclk);
    wr = mem.wr_en;
    wd = mem.wdata;
    @(negedge mclk);
  endtask
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h0d735437));
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    for (int t = 0; t < 80; t++) begin
      kd = (t < 4) ? {t[1], t[1] & t[0]} : 2'($urandom);
      {ext, bank, d, a, s, kh, k} = 21'($urandom);
      {r, fa} = 16'($urandom);
      if (t == 0) k = 8'h9a;
      if (t == 1) k = 8'h35;
      if (t == 2) {r, d} = 9'h000;
      if (t == 3) {s, kh, k} = 14'h23ab;
      if (t[2:0] == 3'h5) begin
        // Undecoded opcode must leave every result alone
        word({8'h0e, k}, 1'b1);
        cmp_mem({wr, 8'h00}, 9'h000);
        cmp_reg({w_o, neg, zer}, e);
        cmp_ptr(ptr, {pm[2], pm[1], pm[0]});
      end
      case (kd)
        2'd0: begin
          word({8'h09, k}, 1'b1);
          e = flg(e[9:2] | k, e[9:2] | k);
          cmp_mem({wr, 8'h00}, 9'h000);
        end
        2'd3: begin
          word({10'h3b8, s, kh}, 1'b1);
          cmp_seq(sw, 1'b1);
          if (k[0]) word(16'h0000, 1'b0);
          word({8'hf0, k}, 1'b1);
          cmp_seq(sw, 1'b0);
          if (s != 2'h3) pm[s] = {kh, k};
          cmp_ptr(ptr, {pm[2], pm[1], pm[0]});
        end
        default: begin
          word({kd == 2'd1 ? 6'h04 : 6'h14, d, a, fa}, 1'b1);
          res = (kd == 2'd1) ? e[9:2] | r : r;
          e = flg(d ? e[9:2] : res, res);
          cmp_mem({wr, wd & {8{d}}}, {d, res & {8{d}}});
        end
      endcase
      cmp_reg({w_o, neg, zer}, e);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
